// ### rtl/afr_top.sv
// access fault error reporting: registers, event and interrupt
// Operation
// - with event output enabled, any fault flag becoming set produces an event.
// - the event output enable is bit 0 of event control, resets to 0, and blocks events.
// - with the interrupt enabled, the request is high while any fault flag is set.
// - writing 0 to bit 0 of the enable clear register leaves the enable unchanged.
// - writing 1 to bit 0 of the enable clear register disables the interrupt request; here status bits set in the mask still raise line 0.
// - bit 0 of the enable clear register reads back the current enable state.
// - the enable set and clear registers share one enable, visible through both.
// - the interrupt request joins shared interrupt line 0 with the other controllers.
//
// Chosen here: register access over Wishbone.
`include "afr_defs.svh"

module afr_top (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         cyc_i,
    input  wire logic                         stb_i,
    input  wire logic                         we_i,
    input  wire logic [`AFR_SEL_W-1:0]        sel_i,
    input  wire logic [`AFR_ADR_W-1:0]        adr_i,
    input  wire logic [`AFR_DAT_W-1:0]        dat_i,
    output logic      [`AFR_DAT_W-1:0]        dat_o,
    output logic                              ack_o,
    output logic                              err_o,
    input  wire logic [`AFR_BUS_FLAGS_W-1:0]  bus_side_fault_flags_i,
    input  wire logic [`AFR_PER_FLAGS_W-1:0]  peripheral_fault_flags_i,
    input  wire logic [`AFR_SHARED_W-1:0]     line0_other_irq_i,
    output logic                              fault_event_o,
    output logic                              irq_line0_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic afr_hit(
        input logic [`AFR_ADR_W-1:0] adr,
        input logic [`AFR_ADR_W-1:0] ofs
    );
        afr_hit = (adr[`AFR_ADR_W-1:2] == ofs[`AFR_ADR_W-1:2]);
    endfunction : afr_hit

    function automatic logic [`AFR_DAT_W-1:0] afr_zext8(
        input logic [`AFR_REG_W-1:0] v
    );
        afr_zext8 = {{(`AFR_DAT_W-`AFR_REG_W){1'b0}}, v};
    endfunction : afr_zext8

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    afr_pkg::afr_wb_req_t req;
    afr_pkg::afr_flags_t  flags;

    assign req.cyc = cyc_i;
    assign req.stb = stb_i;
    assign req.we  = we_i;
    assign req.sel = sel_i;
    assign req.adr = adr_i;
    assign req.dat = dat_i;

    assign flags.bus_side = bus_side_fault_flags_i;
    assign flags.periph   = peripheral_fault_flags_i;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    afr_pkg::afr_bus_st_t       st_r;
    afr_pkg::afr_bus_st_t       st_nxt;
    logic [`AFR_REG_W-1:0]      evctl_r;
    logic [`AFR_REG_W-1:0]      evctl_nxt;
    logic                       ien_r;
    logic                       ien_nxt;
    logic [`AFR_ST_W-1:0]       mask_r;
    logic [`AFR_ST_W-1:0]       mask_nxt;
    logic [`AFR_DAT_W-1:0]      dat_r;
    logic [`AFR_DAT_W-1:0]      dat_nxt;
    logic                       ack_r;
    logic                       err_r;
    logic                       event_r;
    logic                       event_nxt;
    logic                       irq_r;
    logic                       irq_nxt;
    logic [`AFR_ST_W-1:0]       status;
    logic                       bus_rise;
    logic                       per_rise;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire take     = req.cyc & req.stb & (st_r == afr_pkg::st_idle);
    wire wr       = req.cyc & req.stb & req.we & ack_r; // write commits on the ack edge
    wire rd       = take & ~req.we;
    wire lane0    = req.sel[`AFR_LANE0];
    wire hit_ev   = afr_hit(req.adr, `AFR_OFS_EVCTL);
    wire hit_clr  = afr_hit(req.adr, `AFR_OFS_IENCLR);
    wire hit_set  = afr_hit(req.adr, `AFR_OFS_IENSET);
    wire hit_st   = afr_hit(req.adr, `AFR_OFS_STATUS);
    wire hit_msk  = afr_hit(req.adr, `AFR_OFS_MASK);
    wire hit_bfl  = afr_hit(req.adr, `AFR_OFS_BUSFLG);
    wire hit_pfl  = afr_hit(req.adr, `AFR_OFS_PERFLG);
    wire mapped   = hit_ev | hit_clr | hit_set | hit_st
                  | hit_msk | hit_bfl | hit_pfl;
    wire wr_ev    = wr & hit_ev & lane0;
    wire wr_clr   = wr & hit_clr & lane0;
    wire wr_set   = wr & hit_set & lane0;
    wire wr_st    = wr & hit_st & lane0;
    wire wr_msk   = wr & hit_msk & lane0;
    wire bit0     = req.dat[`AFR_BIT_IEN];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    wire [`AFR_REG_W-1:0] evoe_only = {{(`AFR_REG_W-1){1'b0}},
                                       req.dat[`AFR_BIT_EVOE]};

    assign evctl_nxt = wr_ev ? evoe_only : evctl_r;

    // one shared enable behind both set and clear addresses
    assign ien_nxt = (wr_clr & bit0) ? 1'b0 :
                     (wr_set & bit0) ? 1'b1 :
                     ien_r;

    assign mask_nxt = wr_msk ? req.dat[`AFR_ST_W-1:0] : mask_r;

    wire evoe = evctl_r[`AFR_BIT_EVOE];

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [`AFR_REG_W-1:0] ien_rd = {{(`AFR_REG_W-1){1'b0}}, ien_r};
    wire [`AFR_REG_W-1:0] st_rd  = {{(`AFR_REG_W-`AFR_ST_W){1'b0}}, status};
    wire [`AFR_REG_W-1:0] msk_rd = {{(`AFR_REG_W-`AFR_ST_W){1'b0}}, mask_r};

    wire [`AFR_DAT_W-1:0] rd_mux =
        hit_ev  ? afr_zext8(evctl_r) :
        hit_clr ? afr_zext8(ien_rd) :
        hit_set ? afr_zext8(ien_rd) :
        hit_st  ? afr_zext8(st_rd) :
        hit_msk ? afr_zext8(msk_rd) :
        hit_bfl ? afr_zext8(flags.bus_side) :
        hit_pfl ? flags.periph :
        '0;

    assign dat_nxt = rd ? rd_mux : '0;

    // ------------------------------------------------------------
    // bus answer sequencing
    // ------------------------------------------------------------
    always_comb begin
        case (st_r)
            afr_pkg::st_idle: begin
                st_nxt = take ? afr_pkg::st_answer : afr_pkg::st_idle;
            end
            afr_pkg::st_answer: begin
                st_nxt = afr_pkg::st_idle;
            end
            default: begin
                st_nxt = afr_pkg::st_idle;
            end
        endcase
    end

    // ------------------------------------------------------------
    // fault transitions
    // ------------------------------------------------------------
    afr_rise_det #(
        .W (`AFR_BUS_FLAGS_W)
    ) u_bus_rise (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .flags_i (flags.bus_side),
        .rise_o  (bus_rise)
    );

    afr_rise_det #(
        .W (`AFR_PER_FLAGS_W)
    ) u_per_rise (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .flags_i (flags.periph),
        .rise_o  (per_rise)
    );

    wire any_rise = bus_rise | per_rise;
    wire any_flag = (|flags.bus_side) | (|flags.periph);

    // ------------------------------------------------------------
    // sticky status and mask
    // ------------------------------------------------------------
    wire [`AFR_ST_W-1:0] st_set = {per_rise, bus_rise};
    wire [`AFR_ST_W-1:0] st_clr = wr_st ? req.dat[`AFR_ST_W-1:0]
                                        : {`AFR_ST_W{1'b0}};

    afr_sticky #(
        .W (`AFR_ST_W)
    ) u_status (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (st_set),
        .clr_i  (st_clr),
        .stat_o (status)
    );

    // ------------------------------------------------------------
    // event and interrupt
    // ------------------------------------------------------------
    assign event_nxt = evoe & any_rise;

    wire fault_req = ien_r & any_flag;
    wire stat_req  = |(status & mask_r);

    assign irq_nxt = fault_req | stat_req
                   | (|line0_other_irq_i);

    // ------------------------------------------------------------
    // flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r     <= afr_pkg::st_idle;
            evctl_r  <= `AFR_RST_EVCTL;
            ien_r    <= `AFR_RST_IEN;
            mask_r   <= `AFR_RST_MASK;
            dat_r    <= '0;
            ack_r    <= 1'b0;
            err_r    <= 1'b0;
            event_r  <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            evctl_r  <= evctl_nxt;
            ien_r    <= ien_nxt;
            mask_r   <= mask_nxt;
            dat_r    <= dat_nxt;
            ack_r    <= take & mapped;
            err_r    <= take & ~mapped;
            event_r  <= event_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign dat_o         = dat_r;
    assign ack_o         = ack_r;
    assign err_o         = err_r;
    assign fault_event_o = event_r;
    assign irq_line0_o   = irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_rd_clr;
        rd & hit_clr;
    endsequence

    sequence s_rd_set;
        rd & hit_set;
    endsequence

    sequence s_clr_one;
        wr_clr & bit0;
    endsequence

    sequence s_set_one;
        wr_set & bit0;
    endsequence

    a_event_on_rise: assert property (
        (evoe & any_rise) |=> fault_event_o)
        else $error("event missing after flag rise");

    a_event_blocked: assert property (
        !evoe |=> !fault_event_o)
        else $error("event while output disabled");

    a_event_reset_val: assert property (
        $fell(rst_i) |-> !evctl_r[`AFR_BIT_EVOE] ##1 !fault_event_o)
        else $error("event enable not clear after reset");

    a_irq_on_flag: assert property (
        (ien_r & any_flag) |=> irq_line0_o)
        else $error("request missing with flag set");

    a_clr_zero_keeps: assert property (
        (wr_clr & !bit0) |=> (ien_r == $past(ien_r)))
        else $error("zero write changed enable");

    a_clr_one_drops: assert property (
        s_clr_one |=> !ien_r)
        else $error("enable not removed by clear");

    a_clr_irq_removed: assert property (
        s_clr_one ##1 (line0_other_irq_i == '0 && !stat_req) |=> !irq_line0_o)
        else $error("request not removed by clear");

    a_clr_read_state: assert property (
        s_rd_clr |=> ack_o && dat_o[`AFR_BIT_IEN] == $past(ien_r))
        else $error("clear register read wrong");

    a_set_read_shared: assert property (
        s_set_one ##[1:2] s_rd_clr |=> dat_o[`AFR_BIT_IEN])
        else $error("set not visible through clear");

    a_set_read_state: assert property (
        s_rd_set |=> dat_o[`AFR_BIT_IEN] == $past(ien_r))
        else $error("set register read wrong");

    a_line0_shared: assert property (
        (|line0_other_irq_i) |=> irq_line0_o)
        else $error("shared line 0 not driven");

    a_event_single: assert property (
        (fault_event_o && !$past(rst_i, 3)) |-> $past(evoe)
            && ((|($past(flags.bus_side, 2) & ~$past(flags.bus_side, 3)))
             || (|($past(flags.periph, 2) & ~$past(flags.periph, 3)))))
        else $error("event without new transition");

    a_event_held_flag: assert property (
        $stable(flags) [*2] |=> ##1 !fault_event_o)
        else $error("event repeated for held flag");

    a_ack_one_cycle: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    a_err_unmapped: assert property (
        (take & ~mapped) |=> (err_o && !ack_o))
        else $error("unmapped access not refused");

    a_dat_idle_zero: assert property (
        !ack_o |-> (dat_o == '0))
        else $error("read data not zero outside ack");

    a_bus_fault_sticky: assert property (
        bus_rise |=> status[`AFR_ST_BUS])
        else $error("bus-side status bit not set");

    a_per_fault_sticky: assert property (
        per_rise |=> status[`AFR_ST_PER])
        else $error("peripheral status bit not set");

endmodule : afr_top

// ### rtl/afr_defs.svh
// constants of the access fault error reporting block
`ifndef AFR_DEFS_SVH
`define AFR_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define AFR_ADR_W       8
`define AFR_DAT_W       32
`define AFR_SEL_W       4
`define AFR_REG_W       8
`define AFR_BUS_FLAGS_W 8
`define AFR_PER_FLAGS_W 32
`define AFR_SHARED_W    4
`define AFR_ST_W        2

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define AFR_OFS_EVCTL   8'h04
`define AFR_OFS_IENCLR  8'h08
`define AFR_OFS_IENSET  8'h0C
`define AFR_OFS_STATUS  8'h10
`define AFR_OFS_MASK    8'h14
`define AFR_OFS_BUSFLG  8'h18
`define AFR_OFS_PERFLG  8'h1C

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define AFR_RST_EVCTL   8'h00
`define AFR_RST_IEN     1'h0
`define AFR_RST_MASK    2'h0
`define AFR_BIT_EVOE    0
`define AFR_BIT_IEN     0
`define AFR_ST_BUS      0
`define AFR_ST_PER      1
`define AFR_LANE0       0

`endif

// ### rtl/afr_pkg.sv
// types of the access fault error reporting block
package afr_pkg;

    // ------------------------------------------------------------
    // bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } afr_wb_req_t;

    // ------------------------------------------------------------
    // fault flag carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  bus_side;
        logic [31:0] periph;
    } afr_flags_t;

    // ------------------------------------------------------------
    // bus answer states
    // ------------------------------------------------------------
    typedef enum logic {
        st_idle,
        st_answer
    } afr_bus_st_t;

endpackage : afr_pkg

// ### rtl/afr_rise_det.sv
// clear-to-set transition detector over a flag vector
module afr_rise_det #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] flags_i,
    output logic              rise_o
);

    logic [W-1:0] prev_r;
    logic         rise_r;
    wire  [W-1:0] rise_vec = flags_i & ~prev_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= '0;
            rise_r <= 1'b0;
        end else begin
            prev_r <= flags_i;
            rise_r <= |rise_vec;
        end
    end

    assign rise_o = rise_r;

endmodule : afr_rise_det

// ### rtl/afr_sticky.sv
// sticky status bits, write one to clear, set wins
module afr_sticky #(
    parameter int W = 2
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic [W-1:0]      stat_o
);

    logic [W-1:0] stat_r;
    wire  [W-1:0] stat_nxt = (stat_r & ~clr_i) | set_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign stat_o = stat_r;

endmodule : afr_sticky

// ### verif/afr_far_model.sv
// interrupt controller and event system model at the far side
module afr_far_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic event_i,
    input  wire logic irq_i,
    output int        event_cnt_o,
    output logic      irq_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // event pulses counted once per high cycle
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            event_cnt_o <= 0;
            irq_lvl_o   <= 1'b0;
        end else begin
            if (event_i === 1'b1) begin
                event_cnt_o <= event_cnt_o + 1;
            end
            irq_lvl_o <= (irq_i === 1'b1);
        end
    end
endmodule : afr_far_model

// ### verif/tb_afr_top.sv
// register-level bench of the access fault error reporting block
module tb_afr_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [3:0]  sel_i = 4'h0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        err_o;
    logic [7:0]  bflg  = 8'h00;
    logic [31:0] pflg  = 32'h00000000;
    logic [3:0]  oirq  = 4'h0;
    logic        fault_event_o;
    logic        irq_line0_o;
    int          ev_cnt;
    logic        irq_lvl;
    int          failures = 0;
    int          checked  = 0;
    int          cycles   = 0;
    logic [31:0] rd;
    logic        e;
    int          ev0;

    always #12.5 clk_i = ~clk_i;

    afr_top i_dut (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .cyc_i                    (cyc_i),
        .stb_i                    (stb_i),
        .we_i                     (we_i),
        .sel_i                    (sel_i),
        .adr_i                    (adr_i),
        .dat_i                    (dat_i),
        .dat_o                    (dat_o),
        .ack_o                    (ack_o),
        .err_o                    (err_o),
        .bus_side_fault_flags_i   (bflg),
        .peripheral_fault_flags_i (pflg),
        .line0_other_irq_i        (oirq),
        .fault_event_o            (fault_event_o),
        .irq_line0_o              (irq_line0_o)
    );

    afr_far_model i_far (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .event_i     (fault_event_o),
        .irq_i       (irq_line0_o),
        .event_cnt_o (ev_cnt),
        .irq_lvl_o   (irq_lvl)
    );

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'h1;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o;
        e  = (err_o === 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb_xfer

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
        wb_xfer(1'b0, a, 32'h00000000);
        chk(nm, x, rd);
    endtask : rdchk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_cyc

    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        wait_cyc(3);
        rst_i <= 1'b0;
        rdchk(8'h04, 32'h00000000, "evctl reset");
        rdchk(8'h08, 32'h00000000, "ienclr reset");
        rdchk(8'h0C, 32'h00000000, "ienset reset");
        rdchk(8'h10, 32'h00000000, "status reset");
        rdchk(8'h14, 32'h00000000, "mask reset");
        wb_xfer(1'b0, 8'h40, 32'h00000000);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test reset done");
        ev0 = ev_cnt;
        bflg <= 8'h01;
        wait_cyc(5);
        chk("event disabled", ev0, ev_cnt);
        rdchk(8'h10, 32'h00000001, "status bus");
        wb_xfer(1'b1, 8'h10, 32'h00000001);
        rdchk(8'h10, 32'h00000000, "status cleared");
        bflg <= 8'h00;
        $display("test event off done");
        wb_xfer(1'b1, 8'h04, 32'h00000001);
        rdchk(8'h04, 32'h00000001, "evctl set");
        ev0 = ev_cnt;
        pflg <= 32'h00000020;
        wait_cyc(6);
        chk("one pulse held", ev0 + 1, ev_cnt);
        bflg <= 8'h08;
        wait_cyc(6);
        chk("second rise", ev0 + 2, ev_cnt);
        rdchk(8'h1C, 32'h00000020, "per flags");
        bflg <= 8'h00;
        pflg <= 32'h00000000;
        wait_cyc(2);
        wb_xfer(1'b1, 8'h10, 32'h00000003);
        $display("test event on done");
        wb_xfer(1'b1, 8'h0C, 32'h00000001);
        rdchk(8'h08, 32'h00000001, "clr reads en");
        rdchk(8'h0C, 32'h00000001, "set reads en");
        chk("irq no flag", 32'h0, {31'h0, irq_lvl});
        bflg <= 8'h81;
        wait_cyc(4);
        chk("irq flag", 32'h1, {31'h0, irq_lvl});
        rdchk(8'h18, 32'h00000081, "bus flags");
        wb_xfer(1'b1, 8'h08, 32'h00000000);
        rdchk(8'h08, 32'h00000001, "clr zero");
        chk("irq kept", 32'h1, {31'h0, irq_lvl});
        wb_xfer(1'b1, 8'h08, 32'h00000001);
        rdchk(8'h0C, 32'h00000000, "clr one");
        wait_cyc(3);
        chk("irq removed", 32'h0, {31'h0, irq_lvl});
        $display("test enable done");
        oirq <= 4'h2;
        wait_cyc(4);
        chk("shared line", 32'h1, {31'h0, irq_lvl});
        oirq <= 4'h0;
        wait_cyc(4);
        chk("shared idle", 32'h0, {31'h0, irq_lvl});
        wb_xfer(1'b1, 8'h14, 32'h00000001);
        wait_cyc(4);
        chk("masked status", 32'h1, {31'h0, irq_lvl});
        wb_xfer(1'b1, 8'h10, 32'h00000003);
        wait_cyc(4);
        chk("status w1c irq", 32'h0, {31'h0, irq_lvl});
        bflg <= 8'h00;
        $display("test line done");
        wrap_up();
    end
endmodule : tb_afr_top
